// ===== sdh_cmd_data_ctrl.sv
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module sdh_cmd_data_ctrl
   import sdh_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // card link
   input wire logic card_clk,
   input wire logic cmd_in,
   output logic cmd_out,
   output logic cmd_oe,
   // command control unit
   input wire logic cmd_start,
   input wire logic [7:0] cmd_index,
   input wire logic [31:0] cmd_argument,
   input wire logic wait_reply,
   input wire logic long_reply_select,
   // data engine
   input wire logic data_waiting,
   input wire logic last_block_done,
   output logic data_start,
   output logic data_timeout,
   output logic [1:0] transfer_direction_select,
   output logic [3:0] card_data_lines_enable,
   output logic block_or_stream_select,
   output logic [11:0] block_count,
   output logic [11:0] block_length_bytes,
   output logic [1:0] transfer_width,
   output logic dma_select,
   output logic dma_four_beat,
   output logic sdio_irq_window
);
   logic clk_s1_q, clk_s2_q, clk_prev_q, cmd_s1_q, cmd_s2_q;
   logic card_rise, card_fall;
   sdh_cmd_state_t state_q;
   logic [7:0] bit_cnt_q;
   logic [47:0] tx_q;
   logic [135:0] rx_q, rx_full;
   logic [7:0] rx_len;
   logic long_q, wait_q, cmd_out_q, cmd_oe_q;
   logic sent_p, done_p, tout_p, crc_bad;
   logic crc_clr, crc_en, crc_din;
   logic [6:0] crc_val;
   logic [31:0] word0_q, word1_q, word2_q, word3_q;
   logic [7:0] reply_index_q;
   logic [3:0] flags_q, flag_set, flag_clr;
   logic [22:0] timeout_q, dt_cnt_q;
   logic dt_fired_q, data_timeout_q, data_start_q;
   logic [11:0] blklen_q;
   logic [24:0] dctl_q;
   logic [1:0] dir, width;
   logic trig, go_done;
   logic [3:0] irq_cnt_q;
   logic apb_setup, apb_write, wr_status;
   logic [31:0] prdata_q;
   logic pslverr_q;

   // card clock and command line come from outside: two flops each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_s1_q <= 1'b0;
         clk_s2_q <= 1'b0;
         clk_prev_q <= 1'b0;
         cmd_s1_q <= 1'b1;
         cmd_s2_q <= 1'b1;
      end else begin
         clk_s1_q <= card_clk;
         clk_s2_q <= clk_s1_q;
         clk_prev_q <= clk_s2_q;
         cmd_s1_q <= cmd_in;
         cmd_s2_q <= cmd_s1_q;
      end
   end
   assign card_rise = clk_s2_q & ~clk_prev_q;
   assign card_fall = ~clk_s2_q & clk_prev_q;

   // reply frame length and shift view
   assign rx_full = {rx_q[134:0], cmd_s2_q};
   assign rx_len = long_q ? LONG_LEN : SHORT_LEN;

   // command line events
   always_comb begin
      sent_p = 1'b0;
      done_p = 1'b0;
      tout_p = 1'b0;
      crc_bad = 1'b0;
      case (state_q)
         CS_SEND: sent_p = card_fall && bit_cnt_q == CMD_LEN;
         CS_WAIT: tout_p = card_rise && cmd_s2_q &&
            bit_cnt_q == REPLY_TIMEOUT_CLKS - 8'h01;
         CS_RECV: begin
            done_p = card_rise && bit_cnt_q == rx_len - 8'h01;
            crc_bad = done_p && rx_full[7:1] != crc_val;
         end
         default: ;
      endcase
   end

   // checksum feed: command bits 0..39, reply per frame type
   always_comb begin
      crc_clr = (state_q == CS_IDLE && cmd_start) ||
         (state_q == CS_WAIT && card_rise && !cmd_s2_q);
      crc_en = 1'b0;
      crc_din = cmd_s2_q;
      case (state_q)
         CS_SEND: begin
            crc_en = card_fall && bit_cnt_q < CMD_CRC_POS;
            crc_din = tx_q[47];
         end
         CS_WAIT: crc_en = card_rise && !cmd_s2_q && !long_q;
         CS_RECV: crc_en = card_rise && (long_q ?
            (bit_cnt_q >= LONG_CRC_FROM && bit_cnt_q < LONG_CRC_TO) :
            bit_cnt_q < CMD_CRC_POS);
         default: ;
      endcase
   end

   sdh_crc7 u_crc (
      .pclk(pclk),
      .presetn(presetn),
      .clear(crc_clr),
      .enable(crc_en),
      .data_in(crc_din),
      .crc_q(crc_val)
   );

   // command engine: drive on card clock fall, sample on rise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= CS_IDLE;
         bit_cnt_q <= 8'h00;
         tx_q <= 48'h0;
         rx_q <= 136'h0;
         long_q <= 1'b0;
         wait_q <= 1'b0;
         cmd_out_q <= 1'b1;
         cmd_oe_q <= 1'b0;
      end else begin
         case (state_q)
            CS_IDLE: if (cmd_start) begin
               tx_q <= {2'h1, cmd_index[5:0], cmd_argument, 8'h01};
               long_q <= long_reply_select;
               wait_q <= wait_reply;
               bit_cnt_q <= 8'h00;
               state_q <= CS_SEND;
            end
            CS_SEND: if (card_fall) begin
               if (bit_cnt_q == CMD_LEN) begin
                  cmd_oe_q <= 1'b0;
                  cmd_out_q <= 1'b1;
                  bit_cnt_q <= 8'h00;
                  state_q <= wait_q ? CS_WAIT : CS_IDLE;
               end else if (bit_cnt_q == CMD_CRC_POS) begin
                  cmd_oe_q <= 1'b1;
                  cmd_out_q <= crc_val[6];
                  tx_q <= {crc_val[5:0], 1'b1, 41'h0};
                  bit_cnt_q <= bit_cnt_q + 8'h01;
               end else begin
                  cmd_oe_q <= 1'b1;
                  cmd_out_q <= tx_q[47];
                  tx_q <= {tx_q[46:0], 1'b0};
                  bit_cnt_q <= bit_cnt_q + 8'h01;
               end
            end
            CS_WAIT: if (card_rise) begin
               if (!cmd_s2_q) begin
                  rx_q <= 136'h0;
                  bit_cnt_q <= 8'h01;
                  state_q <= CS_RECV;
               end else if (tout_p) begin
                  bit_cnt_q <= 8'h00;
                  state_q <= CS_IDLE;
               end else begin
                  bit_cnt_q <= bit_cnt_q + 8'h01;
               end
            end
            CS_RECV: if (card_rise) begin
               rx_q <= rx_full;
               bit_cnt_q <= done_p ? 8'h00 : bit_cnt_q + 8'h01;
               if (done_p) begin
                  state_q <= CS_IDLE;
               end
            end
            default: state_q <= CS_IDLE;
         endcase
      end
   end
   assign cmd_out = cmd_out_q;
   assign cmd_oe = cmd_oe_q;

   // reply capture into the four words and the index byte
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         word0_q <= 32'h0;
         word1_q <= 32'h0;
         word2_q <= 32'h0;
         word3_q <= 32'h0;
         reply_index_q <= 8'h00;
      end else if (done_p && long_q) begin
         word0_q <= rx_full[127:96];
         word1_q <= rx_full[95:64];
         word2_q <= rx_full[63:32];
         word3_q <= rx_full[31:0];
         reply_index_q <= rx_full[135:128];
      end else if (done_p) begin
         word0_q <= rx_full[39:8];
         word1_q <= {rx_full[7:0], 24'h0};
         word2_q <= 32'h0;
         word3_q <= 32'h0;
         reply_index_q <= rx_full[47:40];
      end
   end

   // sticky status flags, set beats clear
   assign apb_setup = psel & ~penable;
   assign apb_write = psel & penable & pwrite;
   assign wr_status = apb_write && paddr == ADDR_CMD_STATUS;
   assign flag_set = {crc_bad, sent_p, tout_p, done_p};
   assign flag_clr = wr_status ? pwdata[STAT_FLAG_LO +: 4] : 4'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= 4'h0;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   // writable configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_q <= TIMEOUT_RESET;
         blklen_q <= 12'h000;
         dctl_q <= DCTL_RESET;
      end else begin
         // self-clear must not be lost to a write elsewhere
         if (go_done) dctl_q[DC_GO] <= 1'b0;
         if (apb_write && paddr == ADDR_TIMEOUT) timeout_q <= pwdata[22:0];
         if (apb_write && paddr == ADDR_BLOCK_LEN) blklen_q <= pwdata[11:0];
         if (apb_write && paddr == ADDR_DATA_CTRL) dctl_q <= pwdata[24:0];
      end
   end

   // pending start waits for the event its option names
   assign dir = dctl_q[DC_DIR_LO +: 2];
   always_comb begin
      case (dir)
         DIR_TX: trig = !dctl_q[DC_TX_AFTER_REPLY] || done_p;
         DIR_RX: trig = !dctl_q[DC_RX_AFTER_CMD] || sent_p;
         DIR_BUSY: trig = !dctl_q[DC_BUSY_AFTER_CMD] || sent_p;
         default: trig = 1'b1;
      endcase
   end
   assign go_done = dctl_q[DC_GO] && trig;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_start_q <= 1'b0;
      end else begin
         data_start_q <= go_done && dir != DIR_NONE;
      end
   end
   assign data_start = data_start_q;

   // configuration seen by the data engine
   assign width = dctl_q[DC_WIDTH_LO +: 2];
   assign transfer_direction_select = dir;
   assign transfer_width = width == WIDTH_RSVD ? WIDTH_BYTE : width;
   assign dma_select = dctl_q[DC_DMA];
   assign dma_four_beat = dctl_q[DC_DMA] && dctl_q[DC_FOUR_BEAT] &&
      width == WIDTH_WORD;
   assign card_data_lines_enable = dctl_q[DC_FOUR_LINE] ? 4'hF : 4'h1;
   assign block_or_stream_select = dctl_q[DC_BLOCK_MODE];
   assign block_count = dctl_q[DC_BLOCK_MODE] ? dctl_q[11:0] : 12'h000;
   assign block_length_bytes = dctl_q[DC_BLOCK_MODE] ? blklen_q : 12'h000;

   // data or busy wait timeout in card clocks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dt_cnt_q <= 23'h0;
         dt_fired_q <= 1'b0;
         data_timeout_q <= 1'b0;
      end else if (!data_waiting) begin
         dt_cnt_q <= 23'h0;
         dt_fired_q <= 1'b0;
         data_timeout_q <= 1'b0;
      end else begin
         data_timeout_q <= 1'b0;
         if (card_rise && !dt_fired_q) begin
            dt_cnt_q <= dt_cnt_q + 23'h1;
            if (dt_cnt_q + 23'h1 == timeout_q) begin
               dt_fired_q <= 1'b1;
               data_timeout_q <= 1'b1;
            end
         end
      end
   end
   assign data_timeout = data_timeout_q;

   // sdio interrupt period after the last block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_cnt_q <= 4'h0;
      end else if (last_block_done) begin
         irq_cnt_q <= dctl_q[DC_IRQ_PERIOD] ? SDIO_IRQ_LONG
            : SDIO_IRQ_SHORT;
      end else if (card_rise && irq_cnt_q != 4'h0) begin
         irq_cnt_q <= irq_cnt_q - 4'h1;
      end
   end
   assign sdio_irq_window = irq_cnt_q != 4'h0;

   // read data and error latched in the setup phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h0;
         pslverr_q <= 1'b0;
      end else if (apb_setup) begin
         pslverr_q <= 1'b0;
         case (paddr)
            ADDR_CMD_STATUS: prdata_q <= {19'h0, flags_q,
               state_q != CS_IDLE, reply_index_q};
            ADDR_REPLY0: prdata_q <= word0_q;
            ADDR_REPLY1: prdata_q <= word1_q;
            ADDR_REPLY2: prdata_q <= word2_q;
            ADDR_REPLY3: prdata_q <= word3_q;
            ADDR_TIMEOUT: prdata_q <= {9'h0, timeout_q};
            ADDR_BLOCK_LEN: prdata_q <= {20'h0, blklen_q};
            ADDR_DATA_CTRL: prdata_q <= {7'h0, dctl_q};
            default: begin
               prdata_q <= 32'h0;
               pslverr_q <= 1'b1;
            end
         endcase
      end
   end
   assign prdata = prdata_q;
   assign pslverr = pslverr_q;
   assign pready = 1'b1;

   // checks
   a_crc_err_set: assert property (@(posedge pclk) disable iff (!presetn)
      crc_bad |=> flags_q[FLG_CRC]) else $error("crc flag not set");
   a_sent_after_frame: assert property (@(posedge pclk)
      disable iff (!presetn) sent_p |=> flags_q[FLG_SENT] &&
      !cmd_oe) else $error("sent flag or release missing");
   a_reply_timeout: assert property (@(posedge pclk) disable iff (!presetn)
      tout_p |=> flags_q[FLG_TOUT] && state_q == CS_IDLE)
      else $error("timeout not flagged");
   a_set_beats_clear: assert property (@(posedge pclk)
      disable iff (!presetn) (done_p && wr_status &&
      pwdata[STAT_FLAG_LO + FLG_DONE]) |=> flags_q[FLG_DONE])
      else $error("flag lost on clear");
   a_active_start: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == CS_IDLE && cmd_start) |=> state_q == CS_SEND)
      else $error("engine did not start");
   a_index_short: assert property (@(posedge pclk) disable iff (!presetn)
      (done_p && !long_q) |=> reply_index_q == $past(rx_full[47:40]) &&
      word1_q[23:0] == 24'h0) else $error("short reply misplaced");
   a_long_words: assert property (@(posedge pclk) disable iff (!presetn)
      (done_p && long_q) |=> word0_q == $past(rx_full[127:96]) &&
      word3_q == $past(rx_full[31:0])) else $error("long reply misplaced");
   a_tx_after_reply: assert property (@(posedge pclk)
      disable iff (!presetn) (data_start_q && dir == DIR_TX &&
      dctl_q[DC_TX_AFTER_REPLY]) |-> $past(done_p))
      else $error("transmit started early");
   a_go_self_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (go_done && !(apb_write && paddr == ADDR_DATA_CTRL)) |=> !dctl_q[DC_GO])
      else $error("start bit stuck");
endmodule // sdh_cmd_data_ctrl
`default_nettype wire

// ===== sdh_pkg.sv
// Overview of operation
// - reply CRC failure sets status bit 12; writing one clears it.
// - command fully sent sets bit 11, response or not; write one clears.
// - no reply start within 64 card clocks sets bit 10; write one clears.
// - reply fully received sets bit 9; writing one clears it.
// - bit 8 reads high while the command line engine is busy.
// - bits 7..0 hold reply index byte including start and direction bits.
// - short reply: word0 status 31..0, word1[31:24] CRC7 and end bit.
// - long reply: word0 127..96, word1 95..64, word2 63..32, word3 31..0.
// - 23-bit data/busy timeout count, reset value 0x10000, in card clocks.
// - 12-bit block length used in block mode, ignored in stream mode.
// - bit 24 asks four-beat DMA bursts; only meaningful with word width.
// - bits 23..22 give FIFO width: 00 byte, 10 word, 11 reserved.
// - bit 21 picks SDIO interrupt period: two cycles or extended.
// - bit 20 with transmit mode defers data start until reply received.
// - bit 19 with receive mode defers data start until command sent.
// - bit 18 with busy mode defers busy check until command sent.
// - bit 17 picks block mode; block count applies only in block mode.
// - bit 16 clear uses data line 0 only; set uses four lines.
// - bit 15 selects DMA; software clears it after the DMA completes.
// - bits 13..12 give direction; bit 14 starts and self-clears.
// - long reply mode receives 136 bits, otherwise 48 bits.
`default_nettype none
package sdh_pkg;
   // register byte addresses
   localparam logic [31:0] ADDR_CMD_STATUS = 32'h5A00_0010;
   localparam logic [31:0] ADDR_REPLY0 = 32'h5A00_0014;
   localparam logic [31:0] ADDR_REPLY1 = 32'h5A00_0018;
   localparam logic [31:0] ADDR_REPLY2 = 32'h5A00_001C;
   localparam logic [31:0] ADDR_REPLY3 = 32'h5A00_0020;
   localparam logic [31:0] ADDR_TIMEOUT = 32'h5A00_0024;
   localparam logic [31:0] ADDR_BLOCK_LEN = 32'h5A00_0028;
   localparam logic [31:0] ADDR_DATA_CTRL = 32'h5A00_002C;
   // command status fields
   localparam int STAT_FLAG_LO = 9;
   localparam int FLG_CRC = 3;
   localparam int FLG_SENT = 2;
   localparam int FLG_TOUT = 1;
   localparam int FLG_DONE = 0;
   // data control fields
   localparam int DC_FOUR_BEAT = 24;
   localparam int DC_WIDTH_LO = 22;
   localparam int DC_IRQ_PERIOD = 21;
   localparam int DC_TX_AFTER_REPLY = 20;
   localparam int DC_RX_AFTER_CMD = 19;
   localparam int DC_BUSY_AFTER_CMD = 18;
   localparam int DC_BLOCK_MODE = 17;
   localparam int DC_FOUR_LINE = 16;
   localparam int DC_DMA = 15;
   localparam int DC_GO = 14;
   localparam int DC_DIR_LO = 12;
   // reset values
   localparam logic [22:0] TIMEOUT_RESET = 23'h01_0000;
   localparam logic [24:0] DCTL_RESET = 25'h000_0000;
   localparam logic [6:0] CRC_INIT = 7'h00;
   // field codes
   localparam logic [1:0] DIR_NONE = 2'h0;
   localparam logic [1:0] DIR_BUSY = 2'h1;
   localparam logic [1:0] DIR_RX = 2'h2;
   localparam logic [1:0] DIR_TX = 2'h3;
   localparam logic [1:0] WIDTH_BYTE = 2'h0;
   localparam logic [1:0] WIDTH_WORD = 2'h2;
   localparam logic [1:0] WIDTH_RSVD = 2'h3;
   // frame lengths and counts in card clocks
   localparam logic [7:0] CMD_LEN = 8'h30;
   localparam logic [7:0] CMD_CRC_POS = 8'h28;
   localparam logic [7:0] SHORT_LEN = 8'h30;
   localparam logic [7:0] LONG_LEN = 8'h88;
   localparam logic [7:0] LONG_CRC_FROM = 8'h08;
   localparam logic [7:0] LONG_CRC_TO = 8'h80;
   localparam logic [7:0] REPLY_TIMEOUT_CLKS = 8'h40;
   localparam logic [3:0] SDIO_IRQ_SHORT = 4'h2;
   localparam logic [3:0] SDIO_IRQ_LONG = 4'h8;
   // command line engine states
   typedef enum logic [1:0] {CS_IDLE, CS_SEND, CS_WAIT, CS_RECV}
      sdh_cmd_state_t;
endpackage
`default_nettype wire

// ===== sdh_crc7.sv
`timescale 1ns/1ps
`default_nettype none
module sdh_crc7
   import sdh_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // serial feed
   input wire logic clear,
   input wire logic enable,
   input wire logic data_in,
   // running checksum
   output logic [6:0] crc_q
);
   // one serial step of x^7 + x^3 + 1
   function automatic logic [6:0] crc7_step(input logic [6:0] c,
                                            input logic d);
      logic fb;
      fb = d ^ c[6];
      crc7_step = {c[5:3], c[2] ^ fb, c[1:0], fb};
   endfunction

   // clear may coincide with the first bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_q <= CRC_INIT;
      end else if (clear) begin
         crc_q <= enable ? crc7_step(CRC_INIT, data_in) : CRC_INIT;
      end else if (enable) begin
         crc_q <= crc7_step(crc_q, data_in);
      end
   end
endmodule // sdh_crc7
`default_nettype wire

// ===== sdh_card_model.sv
`timescale 1ns/1ps
`default_nettype none
module sdh_card_model (
   // link
   input wire logic card_clk,
   input wire logic line,
   input wire logic host_oe,
   output logic card_oe,
   output logic card_bit,
   // reply setup
   input wire logic mute,
   input wire logic long_rsp,
   input wire logic bad_crc,
   input wire logic [5:0] gap,
   input wire logic [5:0] rsp_index,
   input wire logic [127:0] body,
   // what the card saw and sent
   output logic [47:0] cmd_seen,
   output logic [6:0] crc_sent
);
   logic [135:0] frame;
   int n;
   // crc7 over msb-first bits
   function automatic logic [6:0] crc7(input logic [127:0] v, input int len);
      logic [6:0] c;
      c = 7'h00;
      for (int i = len - 1; i >= 0; i--)
         c = {c[5:0], 1'b0} ^ ((v[i] ^ c[6]) ? 7'h09 : 7'h00);
      return c;
   endfunction
   // take the command on falls, answer after gap falls
   initial begin
      card_oe = 1'b0;
      card_bit = 1'b1;
      cmd_seen = '0;
      crc_sent = 7'h00;
      forever begin
         @(negedge card_clk);
         if (host_oe === 1'b1 && line === 1'b0) begin
            cmd_seen = '0;
            for (int i = 0; i < 47; i++) begin
               @(negedge card_clk);
               cmd_seen = {cmd_seen[46:0], line};
            end
            if (!mute) begin
               crc_sent = long_rsp ? crc7(body >> 8, 120) :
                  crc7({2'b00, rsp_index, body[31:0]}, 40);
               frame = long_rsp ?
                  {8'h3F, body[127:8], crc_sent ^ {6'h0, bad_crc}, 1'b1} :
                  {88'h0, 2'b00, rsp_index, body[31:0],
                   crc_sent ^ {6'h0, bad_crc}, 1'b1};
               n = long_rsp ? 136 : 48;
               repeat (gap) @(negedge card_clk);
               for (int i = n - 1; i >= 0; i--) begin
                  card_oe = 1'b1;
                  card_bit = frame[i];
                  @(negedge card_clk);
               end
               card_oe = 1'b0;
               card_bit = 1'b1;
            end
         end
      end
   end
endmodule // sdh_card_model
`default_nettype wire

// ===== sdh_cmd_data_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sdh_cmd_data_ctrl_bench
   import sdh_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rd_e;
   logic [31:0] paddr, pwdata, prdata, rd_v, arg;
   logic card_clk, cmd_out, cmd_oe, cmd_line, card_oe, card_bit;
   logic cmd_start, wait_reply, long_sel, data_waiting, last_block_done;
   logic [7:0] cmd_index;
   logic data_start, data_timeout, four_beat, dma_sel, bos, irq_win;
   logic [1:0] dir, width;
   logic [3:0] lines;
   logic [11:0] blk_cnt, blk_len;
   logic mute, bad_crc;
   logic [5:0] gap;
   logic [127:0] body;
   logic [47:0] cmd_seen;
   logic [6:0] crc_sent;
   int error_cnt, checks_done, ds_cnt, dt_cnt, d0;
   // pulled-up command line
   assign cmd_line = cmd_oe ? cmd_out : (card_oe ? card_bit : 1'b1);
   sdh_cmd_data_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .card_clk(card_clk), .cmd_in(cmd_line), .cmd_out(cmd_out),
      .cmd_oe(cmd_oe), .cmd_start(cmd_start), .cmd_index(cmd_index),
      .cmd_argument(arg), .wait_reply(wait_reply),
      .long_reply_select(long_sel), .data_waiting(data_waiting),
      .last_block_done(last_block_done), .data_start(data_start),
      .data_timeout(data_timeout), .transfer_direction_select(dir),
      .card_data_lines_enable(lines), .block_or_stream_select(bos),
      .block_count(blk_cnt), .block_length_bytes(blk_len),
      .transfer_width(width), .dma_select(dma_sel),
      .dma_four_beat(four_beat), .sdio_irq_window(irq_win));
   sdh_card_model card_u (.card_clk(card_clk), .line(cmd_line),
      .host_oe(cmd_oe), .card_oe(card_oe), .card_bit(card_bit),
      .mute(mute), .long_rsp(long_sel), .bad_crc(bad_crc), .gap(gap),
      .rsp_index(cmd_index[5:0]), .body(body), .cmd_seen(cmd_seen),
      .crc_sent(crc_sent));
   // clocks, card clock free running out of phase
   initial begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end
   initial begin
      card_clk = 1'b0;
      #37;
      forever #100 card_clk = ~card_clk;
   end
   // count single-cycle pulses
   always @(posedge pclk) begin
      if (data_start === 1'b1) ds_cnt++;
      if (data_timeout === 1'b1) dt_cnt++;
   end
   task automatic results;
      if (error_cnt == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic hang;
      error_cnt++;
      $display("MISMATCH %0t wait ran out", $time);
      results();
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer, held until pready
   task automatic apb(input logic wr, input logic [31:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) hang();
      rd_v = prdata;
      rd_e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd_v, exp);
   endtask
   task automatic wait_flag(input int b);
      int n;
      n = 0;
      do begin
         apb(1'b0, ADDR_CMD_STATUS, 32'h0);
         n++;
      end while (rd_v[b] !== 1'b1 && n < 2000);
      if (n >= 2000) hang();
   endtask
   // start a command and check it went out on the wire
   task automatic issue(input logic [5:0] idx, input logic l);
      cmd_index <= {2'b00, idx};
      wait_reply <= 1'b1;
      long_sel <= l;
      cmd_start <= 1'b1;
      @(posedge pclk);
      cmd_start <= 1'b0;
      @(posedge pclk);
      apb(1'b0, ADDR_CMD_STATUS, 32'h0);
      chk({31'h0, rd_v[8]}, 32'h1);
      wait_flag(11);
      chk({24'h0, cmd_seen[47:40]}, {24'h0, 2'b01, idx});
      chk(cmd_seen[39:8], arg);
      chk({31'h0, cmd_seen[0]}, 32'h1);
   endtask
   task automatic irq_len(input logic [31:0] dc, input int cc);
      int n, k;
      n = 0;
      k = 0;
      apb(1'b1, ADDR_DATA_CTRL, dc);
      last_block_done <= 1'b1;
      @(posedge pclk);
      last_block_done <= 1'b0;
      while (irq_win !== 1'b1 && k < 40) begin
         @(posedge pclk);
         k++;
      end
      while (irq_win === 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(n > cc * 8 - 8 && n <= cc * 8 + 1), 32'h1);
   endtask
   task automatic sc_reset;
      for (int i = 0; i < 8; i++)
         rd(ADDR_CMD_STATUS + 32'(4 * i), (i == 5) ? 32'h1_0000 : 32'h0);
      apb(1'b1, ADDR_REPLY0, 32'hFFFF_FFFF);
      rd(ADDR_REPLY0, 32'h0);
      apb(1'b0, 32'h5A00_0040, 32'h0);
      chk({31'h0, rd_e}, 32'h1);
      apb(1'b1, ADDR_TIMEOUT, 32'hFFFF_FFFF);
      rd(ADDR_TIMEOUT, 32'h007F_FFFF);
      apb(1'b1, ADDR_BLOCK_LEN, 32'hFFFF_FFFF);
      rd(ADDR_BLOCK_LEN, 32'h0000_0FFF);
   endtask
   task automatic sc_fields;
      apb(1'b1, ADDR_BLOCK_LEN, 32'h0000_07FC);
      irq_len(32'h01A3_8ABC, 8);
      rd(ADDR_DATA_CTRL, 32'h01A3_8ABC);
      chk({8'h0, blk_len, blk_cnt}, 32'h007F_CABC);
      chk({lines, width, four_beat, dma_sel, bos}, 32'h1F7);
      irq_len(32'h00C0_0ABC, 2);
      chk({8'h0, blk_len, blk_cnt}, 32'h0);
      chk({lines, width, four_beat, dma_sel, bos}, 32'h020);
   endtask
   task automatic sc_modes;
      for (int m = 0; m < 4; m++) begin
         d0 = ds_cnt;
         apb(1'b1, ADDR_DATA_CTRL, 32'h4000 | 32'(m << 12));
         repeat (4) @(posedge pclk);
         chk(32'(ds_cnt - d0), 32'(m != 0));
         chk({30'h0, dir}, 32'(m));
      end
   endtask
   task automatic sc_short;
      apb(1'b1, ADDR_DATA_CTRL, 32'h0010_7000);
      d0 = ds_cnt;
      issue(6'h11, 1'b0);
      chk(32'(ds_cnt - d0), 32'h0);
      wait_flag(9);
      chk(32'(ds_cnt - d0), 32'h1);
      rd(ADDR_CMD_STATUS, 32'h0000_0A11);
      rd(ADDR_REPLY0, body[31:0]);
      rd(ADDR_REPLY1, {crc_sent, 1'b1, 24'h0});
      rd(ADDR_REPLY2, 32'h0);
      rd(ADDR_REPLY3, 32'h0);
      rd(ADDR_DATA_CTRL, 32'h0010_3000);
      apb(1'b1, ADDR_CMD_STATUS, 32'h0000_1EFF);
      rd(ADDR_CMD_STATUS, 32'h0000_0011);
   endtask
   task automatic sc_long;
      bad_crc <= 1'b1;
      gap <= 6'd40;
      issue(6'h02, 1'b1);
      wait_flag(9);
      rd(ADDR_CMD_STATUS, 32'h0000_1A3F);
      rd(ADDR_REPLY0, body[127:96]);
      rd(ADDR_REPLY1, body[95:64]);
      rd(ADDR_REPLY2, body[63:32]);
      rd(ADDR_REPLY3, {body[31:8], crc_sent ^ 7'h01, 1'b1});
      apb(1'b1, ADDR_CMD_STATUS, 32'h0000_1E00);
      rd(ADDR_CMD_STATUS, 32'h0000_003F);
   endtask
   task automatic sc_timeout;
      bad_crc <= 1'b0;
      mute <= 1'b1;
      apb(1'b1, ADDR_DATA_CTRL, 32'h0008_6000);
      d0 = ds_cnt;
      repeat (4) @(posedge pclk);
      chk(32'(ds_cnt - d0), 32'h0);
      issue(6'h07, 1'b0);
      chk(32'(ds_cnt - d0), 32'h1);
      wait_flag(10);
      chk(rd_v & 32'h0000_1F00, 32'h0000_0C00);
      apb(1'b1, ADDR_CMD_STATUS, 32'h0000_1E00);
      rd(ADDR_CMD_STATUS, 32'h0000_003F);
   endtask
   task automatic sc_dtime;
      int n;
      n = 0;
      apb(1'b1, ADDR_TIMEOUT, 32'h0000_0005);
      d0 = dt_cnt;
      data_waiting <= 1'b1;
      while (dt_cnt == d0 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      data_waiting <= 1'b0;
      chk(32'(n >= 30 && n <= 52), 32'h1);
   endtask
   // main sequence
   initial begin
      error_cnt = 0;
      checks_done = 0;
      ds_cnt = 0;
      dt_cnt = 0;
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {cmd_start, cmd_index, wait_reply, long_sel} = '0;
      {data_waiting, last_block_done, mute, bad_crc} = '0;
      arg = 32'hC0DE_5A17;
      gap = 6'd4;
      body = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      sc_reset();
      sc_fields();
      sc_modes();
      sc_short();
      sc_long();
      sc_timeout();
      sc_dtime();
      results();
   end
endmodule // sdh_cmd_data_ctrl_bench
`default_nettype wire
